// *** pkg/pbfc_pkg.sv ***
// Purpose: shared constants of the bridge function control block
// Assumes: 8-bit registers packed into the config dword at bridge_function_control_1
// Notes: bit positions are within each register byte
package pbfc_pkg;
  localparam logic [7:0] PBFC_IDX_CTL1 = 8'h40;
  localparam logic [7:0] PBFC_IDX_CTL2 = 8'h41;
  localparam logic [7:0] PBFC_IDX_CTL3 = 8'h42;
  localparam logic [7:0] PBFC_IDX_RSVD43 = 8'h43;
  localparam logic [5:0] PBFC_DW_CTL = 6'h10;
  localparam logic [2:0] PBFC_FN_BRIDGE = 3'h0;
  localparam logic [2:0] PBFC_FN_PM = 3'h1;
  localparam logic [2:0] PBFC_FN_IDE = 3'h2;
  localparam logic [7:0] PBFC_RST_CTL1 = 8'h89;
  localparam logic [7:0] PBFC_RST_CTL2 = 8'h10;
  localparam logic [7:0] PBFC_RST_CTL3 = 8'hac;
  // ctl1 fields
  localparam int PBFC_C1_WBUF = 3;
  localparam logic [7:0] PBFC_C1_WMASK = 8'hf8;
  localparam logic [7:0] PBFC_C1_ONES = 8'h01;
  // ctl2 fields
  localparam int PBFC_C2_SINGLE = 7;
  localparam int PBFC_C2_IDE_TRAP = 6;
  localparam int PBFC_C2_PERR_SERR = 5;
  localparam int PBFC_C2_XWBUF = 4;
  localparam int PBFC_C2_PM_TRAP = 3;
  localparam int PBFC_C2_SUB_HI = 2;
  localparam int PBFC_C2_SUB_LO = 1;
  localparam int PBFC_C2_BR_TRAP = 0;
  // ctl3 fields
  localparam int PBFC_C3_USB_PIN = 7;
  localparam int PBFC_C3_USB_STAT = 6;
  localparam int PBFC_C3_DELAYED = 5;
  localparam int PBFC_C3_USB_DMA = 4;
  localparam int PBFC_C3_NO_ARB = 3;
  localparam int PBFC_C3_HOLD = 2;
  // subtractive decode codes and claim clocks
  localparam logic [1:0] PBFC_SUB_DEFAULT = 2'h0;
  localparam logic [1:0] PBFC_SUB_SLOW = 2'h1;
  localparam logic [2:0] PBFC_SUB_CLK_DEFAULT = 3'h4;
  localparam logic [2:0] PBFC_SUB_CLK_SLOW = 3'h3;
  localparam logic [2:0] PBFC_SUB_CLK_FIRST = 3'h1;
  // write buffer size in bytes
  localparam int PBFC_WBUF_BYTES = 16;
  localparam int PBFC_WORD_BYTES = 4;
endpackage

// *** hw/pbfc_sync.sv ***
// Purpose: three-stage input synchroniser, per bit
// Assumes: inputs come from outside the clock domain
// Notes: a change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pbfc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } pbfc_sync_state_t;

  pbfc_sync_state_t st_reg;
  pbfc_sync_state_t st_next;

  if (W < 1) begin : g_bad_w
    $error("pbfc_sync: W must be at least 1");
  end

  always_comb begin
    st_next = st_reg;
    st_next.s1 = i_async;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // a bit follows stage three only where stages two and three agree
    st_next.out = (st_reg.s3 & ~(st_reg.s2 ^ st_reg.s3))
                  | (st_reg.out & (st_reg.s2 ^ st_reg.s3));
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.out;
endmodule
`default_nettype wire

// *** hw/pbfc_wbuf.sv ***
// Purpose: small write buffer from internal bus to pci side
// Assumes: one word pushed or popped per cycle at most
// Notes: capacity drops to one word while buffering is off
`timescale 1ns/100ps
`default_nettype none
module pbfc_wbuf #(
  parameter int DATA_W = 32,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_limit_one,
  input wire logic i_valid,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [DATA_W-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CAP_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CAP_ONE = (AW + 1)'(1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic out_valid;
    logic [DATA_W-1:0] out_data;
  } pbfc_wbuf_state_t;

  pbfc_wbuf_state_t st_reg;
  pbfc_wbuf_state_t st_next;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pbfc_wbuf: DEPTH must be a power of two, at least 2");
  end

  logic [AW:0] total;
  logic [AW:0] cap;
  assign total = st_reg.cnt + (AW + 1)'(st_reg.out_valid);
  assign cap = i_limit_one ? CAP_ONE : CAP_FULL;
  assign o_ready = (total < cap);

  always_comb begin
    st_next = st_reg;
    if (i_valid && o_ready) begin
      st_next.mem[st_reg.wp] = i_data;
      st_next.wp = (st_reg.wp == LAST) ? '0 : st_reg.wp + AW'(1);
      st_next.cnt = st_next.cnt + (AW + 1)'(1);
    end
    if (i_ready || !st_reg.out_valid) begin
      st_next.out_valid = 1'b0;
      if (st_reg.cnt != '0) begin
        st_next.out_valid = 1'b1;
        st_next.out_data = st_reg.mem[st_reg.rp];
        st_next.rp = (st_reg.rp == LAST) ? '0 : st_reg.rp + AW'(1);
        st_next.cnt = st_next.cnt - (AW + 1)'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_valid = st_reg.out_valid;
  assign o_data = st_reg.out_data;
endmodule
`default_nettype wire

// *** hw/pbfc_top.sv ***
// What this block does
// R1: ctl1 bit 3 turns the pci slave write buffer on or off.
// R2: ctl1 bit 0 ignores writes and reads one; bits 2:1 kept zero.
// R3: software keeps ctl1 bits 6 and 5 cleared normally.
// R4: ctl2 bit 7 set forces single accesses; clear allows bursts.
// R5: ide trap bit makes ide header accesses raise a trap instead.
// R6: each trap reports top status bit 9 and second status bit 5.
// R7: ctl2 bit 5 cascades any parity error onto the system error pin.
// R8: ctl2 bit 4 allows 16-byte buffering of internal-to-pci writes.
// R9: power-management trap bit traps that function's header accesses.
// R10: ctl2 bits 2:1 pick claim clock four, three, or no claiming.
// R11: software picks the earlier point only with fast decoders.
// R12: software disables subtractive claiming only with great care.
// R13: bridge trap bit traps bridge header accesses except 40h-43h.
// R14: ctl3 bit 7 lets usb interrupt pull the interrupt pin low.
// R15: routing bit reports usb interrupts at top status bit 14.
// R16: ctl3 bit 5 allows delayed transactions as a target.
// R17: ctl3 bit 4 gives usb dma priority over other dma.
// R18: ctl3 bit 3 buffers target cycles without internal-bus arbitration.
// R19: software leaves the hold-request enable bit at its reset one.
// R20: ctl2 resets to 10h.
// R21: ctl1 resets to 89h.
// R22: clearing hold-request enable risks faulty arbitration.
// R23: registers reached by function-0 config cycles with byte enables.
//
// Purpose: bridge function control registers and the logic they steer
// Assumes: pci bus signals are on i_clk; usb request is asynchronous
// Notes: config answers one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module pbfc_top
  import pbfc_pkg::*;
#(
  parameter int WBUF_DATA_W = 32
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cfg_req,
  input wire logic i_cfg_write,
  input wire logic [2:0] i_cfg_func,
  input wire logic [7:0] i_cfg_index,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_trapped,
  output logic o_cfg_forward,
  output logic o_smi_top_set,
  output logic o_smi_second_set,
  output logic o_usb_top_set,
  input wire logic i_usb_smi_req,
  output logic o_mgmt_interrupt_out_n,
  input wire logic i_perr_driven,
  input wire logic i_perr_n,
  output logic o_serr_out,
  output logic o_serr_oe,
  input wire logic i_frame_n,
  input wire logic i_devsel_n,
  output logic o_sub_claim,
  output logic o_slave_wbuf_en,
  output logic o_single_access,
  output logic o_delayed_en,
  output logic o_usb_dma_priority,
  output logic o_no_arb_buffer,
  output logic o_hold_req_en,
  output logic [4:0] o_ctl1_misc,
  input wire logic i_xw_valid,
  input wire logic [WBUF_DATA_W-1:0] i_xw_data,
  output logic o_xw_ready,
  output logic o_pw_valid,
  output logic [WBUF_DATA_W-1:0] o_pw_data,
  input wire logic i_pw_ready
);
  localparam int WBUF_WORDS = PBFC_WBUF_BYTES / PBFC_WORD_BYTES;

  typedef enum logic [1:0] {
    PBFC_SUB_IDLE,
    PBFC_SUB_COUNT,
    PBFC_SUB_WAIT_END
  } pbfc_sub_t;

  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic ack;
    logic [31:0] rdata;
    logic trapped;
    logic forward;
    logic top_set;
    logic second_set;
    logic usb_top_set;
    logic usb_prev;
    logic smi_n;
    logic serr;
    logic frame_prev;
    pbfc_sub_t sub;
    logic [2:0] sub_cnt;
    logic [2:0] sub_target;
    logic sub_claim;
  } pbfc_top_state_t;

  pbfc_top_state_t st_reg;
  pbfc_top_state_t st_next;

  // elaboration checks: buffer shape, claim points, fixed bits
  if (WBUF_DATA_W != PBFC_WORD_BYTES * 8) begin : g_bad_width
    $error("pbfc_top: WBUF_DATA_W must match the word size");
  end

  if (WBUF_WORDS < 2) begin : g_bad_depth
    $error("pbfc_top: write buffer needs at least two words");
  end

  if (WBUF_WORDS * PBFC_WORD_BYTES != PBFC_WBUF_BYTES) begin : g_bad_bytes
    $error("pbfc_top: buffer bytes must be whole words");
  end

  if ((WBUF_WORDS & (WBUF_WORDS - 1)) != 0) begin : g_bad_pow2
    $error("pbfc_top: buffer depth must be a power of two");
  end

  if (PBFC_SUB_CLK_SLOW >= PBFC_SUB_CLK_DEFAULT) begin : g_bad_order
    $error("pbfc_top: slow claim point must precede the default");
  end

  if (PBFC_SUB_CLK_FIRST >= PBFC_SUB_CLK_SLOW) begin : g_bad_first
    $error("pbfc_top: claim count must start before the slow point");
  end

  if (PBFC_C2_SUB_HI != PBFC_C2_SUB_LO + 1) begin : g_bad_field
    $error("pbfc_top: decode field bits must be adjacent");
  end

  if ((PBFC_RST_CTL1 & ~PBFC_C1_WMASK) != PBFC_C1_ONES) begin : g_bad_rst1
    $error("pbfc_top: ctl1 reset must hold the fixed low bits");
  end

  if (!PBFC_C1_WMASK[PBFC_C1_WBUF]) begin : g_bad_wmask
    $error("pbfc_top: write buffer bit must be writable");
  end

  if (!PBFC_RST_CTL3[PBFC_C3_HOLD]) begin : g_bad_rst3
    $error("pbfc_top: hold request enable must reset to one");
  end

  // claim clock for a subtractive decode code; zero means no claim
  function automatic logic [2:0] claim_clock(input logic [1:0] mode);
    logic [2:0] c;
    c = 3'h0;
    unique case (mode)
      PBFC_SUB_DEFAULT: c = PBFC_SUB_CLK_DEFAULT;
      PBFC_SUB_SLOW: c = PBFC_SUB_CLK_SLOW;
      default: c = 3'h0;
    endcase
    return c;
  endfunction

  // dword index of the control registers within the header
  function automatic logic is_ctl_dword(input logic [7:0] idx);
    return idx[7:2] == PBFC_DW_CTL;
  endfunction

  // trap decision for a config access
  function automatic logic is_trapped(input logic [7:0] c2,
                                      input logic [2:0] fn,
                                      input logic [7:0] idx);
    logic t;
    t = 1'b0;
    if (fn == PBFC_FN_BRIDGE) begin
      t = c2[PBFC_C2_BR_TRAP] && !is_ctl_dword(idx); // see R13
    end else if (fn == PBFC_FN_PM) begin
      t = c2[PBFC_C2_PM_TRAP]; // see R9
    end else if (fn == PBFC_FN_IDE) begin
      t = c2[PBFC_C2_IDE_TRAP]; // see R5
    end
    return t;
  endfunction

  // byte merge for one register lane
  function automatic logic [7:0] merge_byte(input logic [7:0] old,
                                            input logic [7:0] wr,
                                            input logic en,
                                            input logic [7:0] wmask);
    return en ? ((old & ~wmask) | (wr & wmask)) : old;
  endfunction

  logic usb_sync;
  logic perr_sync_n;
  logic usb_level;
  logic perr_seen;
  logic trap_hit;
  logic own_hit;
  logic [1:0] sub_mode;
  logic frame_start;
  logic [31:0] ctl_word;

  pbfc_sync #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({i_usb_smi_req, ~i_perr_n}),
    .o_sync({usb_sync, perr_sync_n})
  );

  assign usb_level = usb_sync;
  assign perr_seen = perr_sync_n || i_perr_driven;
  assign trap_hit = i_cfg_req && is_trapped(st_reg.ctl2, i_cfg_func,
                                            i_cfg_index);
  assign own_hit = i_cfg_req && !trap_hit
                   && (i_cfg_func == PBFC_FN_BRIDGE)
                   && is_ctl_dword(i_cfg_index);
  assign sub_mode = st_reg.ctl2[PBFC_C2_SUB_HI:PBFC_C2_SUB_LO];
  assign frame_start = st_reg.frame_prev && !i_frame_n;
  // 43h reads zero; bits 2:1 of ctl1 read zero, bit 0 reads one
  assign ctl_word = {8'h00, st_reg.ctl3, st_reg.ctl2,
                     (st_reg.ctl1 & PBFC_C1_WMASK) | PBFC_C1_ONES}; // see R2

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.trapped = 1'b0;
    st_next.forward = 1'b0;
    st_next.top_set = 1'b0;
    st_next.second_set = 1'b0;
    st_next.usb_top_set = 1'b0;
    st_next.sub_claim = 1'b0;

    // config access port
    if (i_cfg_req) begin
      st_next.ack = 1'b1;
      st_next.rdata = '0;
      if (trap_hit) begin
        st_next.trapped = 1'b1; // see R5
        st_next.top_set = 1'b1; // see R6
        st_next.second_set = 1'b1; // see R6
      end else if (own_hit) begin
        st_next.rdata = i_cfg_write ? '0 : ctl_word; // see R23
        if (i_cfg_write) begin
          st_next.ctl1 = merge_byte(st_reg.ctl1, i_cfg_wdata[7:0],
                                    i_cfg_be[0], PBFC_C1_WMASK); // see R2
          st_next.ctl2 = merge_byte(st_reg.ctl2, i_cfg_wdata[15:8],
                                    i_cfg_be[1], 8'hff); // see R23
          st_next.ctl3 = merge_byte(st_reg.ctl3, i_cfg_wdata[23:16],
                                    i_cfg_be[2], 8'hff); // see R23
        end
      end else begin
        st_next.forward = 1'b1;
      end
    end

    // usb management interrupt routing
    st_next.usb_prev = usb_level;
    if (usb_level && !st_reg.usb_prev) begin
      st_next.usb_top_set = st_reg.ctl3[PBFC_C3_USB_STAT]; // see R15
    end
    st_next.smi_n = !(usb_level && st_reg.ctl3[PBFC_C3_USB_PIN]); // see R14

    // parity error cascade
    st_next.serr = st_reg.ctl2[PBFC_C2_PERR_SERR] && perr_seen; // see R7

    // subtractive decode claim point
    st_next.frame_prev = i_frame_n;
    unique case (st_reg.sub)
      PBFC_SUB_IDLE: begin
        if (frame_start && claim_clock(sub_mode) != 3'h0) begin // see R10
          st_next.sub = PBFC_SUB_COUNT;
          st_next.sub_cnt = PBFC_SUB_CLK_FIRST;
          st_next.sub_target = claim_clock(sub_mode); // see R10
        end
      end
      PBFC_SUB_COUNT: begin
        st_next.sub_cnt = st_reg.sub_cnt + 3'h1;
        if (!i_devsel_n) begin
          st_next.sub = PBFC_SUB_WAIT_END;
        end else if (st_next.sub_cnt == st_reg.sub_target) begin
          st_next.sub_claim = 1'b1; // see R10
          st_next.sub = PBFC_SUB_WAIT_END;
        end
      end
      PBFC_SUB_WAIT_END: begin
        if (i_frame_n) begin
          st_next.sub = PBFC_SUB_IDLE;
        end
      end
      default: begin
        st_next.sub = PBFC_SUB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
      st_reg.ctl1 <= PBFC_RST_CTL1; // see R21
      st_reg.ctl2 <= PBFC_RST_CTL2; // see R20
      st_reg.ctl3 <= PBFC_RST_CTL3;
      st_reg.smi_n <= 1'b1;
      st_reg.frame_prev <= 1'b1;
      st_reg.sub <= PBFC_SUB_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  pbfc_wbuf #(
    .DATA_W(WBUF_DATA_W),
    .DEPTH(WBUF_WORDS)
  ) u_wbuf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_limit_one(!st_reg.ctl2[PBFC_C2_XWBUF]), // see R8
    .i_valid(i_xw_valid),
    .i_data(i_xw_data),
    .o_ready(o_xw_ready),
    .o_valid(o_pw_valid),
    .o_data(o_pw_data),
    .i_ready(i_pw_ready)
  );

  assign o_cfg_ack = st_reg.ack;
  assign o_cfg_rdata = st_reg.rdata;
  assign o_cfg_trapped = st_reg.trapped;
  assign o_cfg_forward = st_reg.forward;
  assign o_smi_top_set = st_reg.top_set;
  assign o_smi_second_set = st_reg.second_set;
  assign o_usb_top_set = st_reg.usb_top_set;
  assign o_mgmt_interrupt_out_n = st_reg.smi_n;
  // open-drain system error: drive low while enabled
  assign o_serr_out = 1'b0;
  assign o_serr_oe = st_reg.serr; // see R7
  assign o_sub_claim = st_reg.sub_claim;
  assign o_slave_wbuf_en = st_reg.ctl1[PBFC_C1_WBUF]; // see R1
  assign o_single_access = st_reg.ctl2[PBFC_C2_SINGLE]; // see R4
  assign o_delayed_en = st_reg.ctl3[PBFC_C3_DELAYED]; // see R16
  assign o_usb_dma_priority = st_reg.ctl3[PBFC_C3_USB_DMA]; // see R17
  assign o_no_arb_buffer = st_reg.ctl3[PBFC_C3_NO_ARB]; // see R18
  assign o_hold_req_en = st_reg.ctl3[PBFC_C3_HOLD];
  assign o_ctl1_misc = st_reg.ctl1[7:3];
endmodule
`default_nettype wire

// *** testbench/pbfc_top_props.sv ***
// Purpose: port-level checks for the bridge function control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every pbfc_top instance
`timescale 1ns/100ps
`default_nettype none
module pbfc_top_props
  import pbfc_pkg::*;
#(
  parameter int WBUF_DATA_W = 32
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cfg_req,
  input wire logic i_cfg_write,
  input wire logic [2:0] i_cfg_func,
  input wire logic [7:0] i_cfg_index,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_cfg_trapped,
  input wire logic o_cfg_forward,
  input wire logic o_smi_top_set,
  input wire logic o_smi_second_set,
  input wire logic o_usb_top_set,
  input wire logic i_usb_smi_req,
  input wire logic o_mgmt_interrupt_out_n,
  input wire logic i_perr_driven,
  input wire logic i_perr_n,
  input wire logic o_serr_oe,
  input wire logic i_frame_n,
  input wire logic i_devsel_n,
  input wire logic o_sub_claim,
  input wire logic o_pw_valid,
  input wire logic [WBUF_DATA_W-1:0] o_pw_data,
  input wire logic i_pw_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_ack_next: assert property (i_cfg_req |=> o_cfg_ack)
    else $error("config answer missing one cycle after request");
  chk_width_bit: assert property (
    o_cfg_ack && !$past(i_cfg_write) && $past(i_cfg_func) == PBFC_FN_BRIDGE
    && $past(i_cfg_index[7:2]) == PBFC_DW_CTL
    |-> o_cfg_rdata[2:0] == 3'h1 && o_cfg_rdata[31:24] == 8'h00)
    else $error("control dword read with wrong fixed bits");
  chk_trap_flags: assert property (o_cfg_trapped |-> o_cfg_ack
    && o_smi_top_set && o_smi_second_set && !o_cfg_forward
    && o_cfg_rdata == 32'h0)
    else $error("trap without both status pulses");
  chk_exempt_idx: assert property (
    i_cfg_req && i_cfg_func == PBFC_FN_BRIDGE
    && i_cfg_index[7:2] == PBFC_DW_CTL |=> !o_cfg_trapped && !o_cfg_forward)
    else $error("control dword access trapped or forwarded");
  chk_sub_point: assert property (o_sub_claim |-> $past(i_devsel_n)
    && ($past(i_frame_n, 5) && !$past(i_frame_n, 4)
    || $past(i_frame_n, 4) && !$past(i_frame_n, 3)) ##1 !o_sub_claim)
    else $error("subtractive claim at wrong clock");
  chk_serr_quiet: assert property (
    (!i_perr_driven && i_perr_n) [*6] |=> !o_serr_oe)
    else $error("system error driven without parity error");
  chk_usb_pin: assert property (!o_mgmt_interrupt_out_n |->
    $past(i_usb_smi_req, 3) || $past(i_usb_smi_req, 4)
    || $past(i_usb_smi_req, 5))
    else $error("interrupt pin low without usb request");
  chk_usb_top: assert property (o_usb_top_set |->
    ($past(i_usb_smi_req, 3) || $past(i_usb_smi_req, 4)
    || $past(i_usb_smi_req, 5)) ##1 !o_usb_top_set)
    else $error("usb status pulse without request or too long");
  chk_pw_hold: assert property (o_pw_valid && !i_pw_ready |=>
    o_pw_valid && $stable(o_pw_data))
    else $error("buffered word dropped while stalled");
endmodule

bind pbfc_top pbfc_top_props #(.WBUF_DATA_W(WBUF_DATA_W)) u_props (.*);
`default_nettype wire

// *** testbench/pbfc_pci_agent.sv ***
// Purpose: pci initiator plus one other target on the shared bus
// Assumes: single data phase frames
// Notes: devsel released to its pull-up level after two clocks
`timescale 1ns/100ps
`default_nettype none
module pbfc_pci_agent (
  input wire logic i_clk,
  output logic o_frame_n,
  output logic o_devsel_n
);
  initial begin
    o_frame_n = 1'b1;
    o_devsel_n = 1'b1;
  end
  // dclk: clock at which the other target claims, 0 for none
  task automatic run(input int dclk);
    for (int c = 1; c <= 7; c++) begin
      @(negedge i_clk);
      o_frame_n = (c != 1);
      o_devsel_n = !(dclk != 0 && c >= dclk && c < dclk + 2);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/pbfc_top_tb.sv ***
// Purpose: self-checking bench for the bridge function control block
// Assumes: inputs change on falling edges
// Notes: config answers are read one falling edge after the request
`timescale 1ns/100ps
`default_nettype none
module pbfc_top_tb;
  import pbfc_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cfg_req = 1'b0;
  logic i_cfg_write = 1'b0;
  logic [2:0] i_cfg_func = 3'h0;
  logic [7:0] i_cfg_index = 8'h00;
  logic [3:0] i_cfg_be = 4'h0;
  logic [31:0] i_cfg_wdata = 32'h0;
  logic i_usb_smi_req = 1'b0;
  logic i_perr_driven = 1'b0;
  logic i_perr_n = 1'b1;
  logic i_xw_valid = 1'b0;
  logic [31:0] i_xw_data = 32'h0;
  logic i_pw_ready = 1'b0;
  logic i_frame_n, i_devsel_n;
  logic o_cfg_ack, o_cfg_trapped, o_cfg_forward, o_smi_top_set;
  logic o_smi_second_set, o_usb_top_set, o_mgmt_interrupt_out_n;
  logic o_serr_out, o_serr_oe, o_sub_claim, o_slave_wbuf_en;
  logic o_single_access, o_delayed_en, o_usb_dma_priority;
  logic o_no_arb_buffer, o_hold_req_en, o_xw_ready, o_pw_valid;
  logic [31:0] o_cfg_rdata, o_pw_data;
  logic [4:0] o_ctl1_misc;
  logic [31:0] rd;
  logic trp, fwd;
  logic [3:0] n;
  int got;
  int err_count = 0;
  int checks_done = 0;
  int tbit[3] = '{PBFC_C2_BR_TRAP, PBFC_C2_PM_TRAP, PBFC_C2_IDE_TRAP};
  logic [2:0] tfn[3] = '{PBFC_FN_BRIDGE, PBFC_FN_PM, PBFC_FN_IDE};
  logic [7:0] tix[3] = '{8'h3c, 8'h44, 8'h40};

  pbfc_top dut (.*);
  pbfc_pci_agent host (.i_clk(i_clk), .o_frame_n(i_frame_n),
                       .o_devsel_n(i_devsel_n));

  always #10 i_clk = ~i_clk;

  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cfg(input logic w, input logic [2:0] f,
                     input logic [7:0] x, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge i_clk);
    i_cfg_req = 1'b1;
    i_cfg_write = w;
    i_cfg_func = f;
    i_cfg_index = x;
    i_cfg_be = be;
    i_cfg_wdata = d;
    @(negedge i_clk);
    i_cfg_req = 1'b0;
    rd = o_cfg_rdata;
    trp = o_cfg_trapped;
    fwd = o_cfg_forward;
    chk(o_cfg_ack, 1'b1);
    chk(o_smi_top_set & o_smi_second_set, trp);
  endtask

  task automatic rdctl(input logic [31:0] exp);
    cfg(1'b0, PBFC_FN_BRIDGE, PBFC_IDX_CTL1, 4'hf, 32'h0);
    chk(rd, exp);
  endtask

  // same byte on every lane, only the enabled lane may land
  task automatic wr(input int lane, input logic [7:0] v);
    cfg(1'b1, PBFC_FN_BRIDGE, PBFC_IDX_CTL1, 4'h1 << lane, {4{v}});
  endtask

  task automatic sub(input logic [1:0] code, input int dclk, input int exp);
    wr(1, {4'h1, 1'b0, code, 1'b0});
    got = 0;
    fork
      host.run(dclk);
      for (int c = 1; c <= 7; c++) begin
        @(negedge i_clk);
        if (o_sub_claim === 1'b1) got = c - 1;
      end
    join
    chk(got, exp);
  endtask

  task automatic usb(input logic [7:0] c3, input logic [4:0] exp);
    wr(2, c3);
    i_usb_smi_req = 1'b1;
    n = 4'h0;
    repeat (7) begin
      @(negedge i_clk);
      n = n + o_usb_top_set;
    end
    chk({n, o_mgmt_interrupt_out_n}, exp);
    i_usb_smi_req = 1'b0;
    repeat (7) @(negedge i_clk);
    chk(o_mgmt_interrupt_out_n, 1'b1);
  endtask

  task automatic buf_run(input logic [7:0] c2, input logic [3:0] cap);
    wr(1, c2);
    n = 4'h0;
    i_xw_valid = 1'b1;
    repeat (6) begin
      i_xw_data = {28'h0, n};
      if (o_xw_ready === 1'b1) n++;
      @(negedge i_clk);
    end
    i_xw_valid = 1'b0;
    chk(n, cap);
    for (int k = 0; k < cap; k++) begin
      chk(o_pw_valid, 1'b1);
      chk(o_pw_data, k);
      i_pw_ready = 1'b1;
      @(negedge i_clk);
      i_pw_ready = 1'b0;
      @(negedge i_clk);
    end
    chk(o_pw_valid, 1'b0);
  endtask

  initial begin
    repeat (8) @(negedge i_clk);
    i_resetn = 1'b1;
    chk({o_slave_wbuf_en, o_single_access, o_delayed_en}, 3'h5);
    chk({o_usb_dma_priority, o_no_arb_buffer, o_hold_req_en}, 3'h3);
    rdctl({8'h0, PBFC_RST_CTL3, PBFC_RST_CTL2, PBFC_RST_CTL1});
    wr(0, 8'h00);
    rdctl(32'h00ac1001);
    chk(o_slave_wbuf_en, 1'b0);
    wr(0, 8'hff);
    rdctl(32'h00ac10f9);
    chk({o_slave_wbuf_en, o_ctl1_misc}, 6'h3f);
    wr(0, 8'h89);
    cfg(1'b1, PBFC_FN_BRIDGE, PBFC_IDX_RSVD43, 4'h8, 32'hff000000);
    wr(1, 8'h80);
    rdctl(32'h00ac8089);
    chk(o_single_access, 1'b1);
    wr(1, 8'h10);
    chk(o_single_access, 1'b0);
    wr(2, 8'h1c);
    chk({o_delayed_en, o_usb_dma_priority, o_no_arb_buffer}, 3'h3);
    wr(2, 8'h24);
    chk({o_delayed_en, o_no_arb_buffer}, 2'h2);
    for (int i = 0; i < 3; i++) begin
      wr(1, 8'h10 | (8'h01 << tbit[i]));
      cfg(1'b0, tfn[i], tix[i], 4'hf, 32'h0);
      chk({trp, fwd}, 2'h2);
      chk(rd, 32'h0);
      rdctl({16'h0024, 8'h10 | (8'h01 << tbit[i]), 8'h89});
      wr(1, 8'h10);
      cfg(1'b0, tfn[i], tix[i], 4'hf, 32'h0);
      chk({trp, fwd}, 2'h1);
    end
    sub(2'h0, 0, 4);
    sub(2'h1, 0, 3);
    sub(2'h2, 0, 0);
    sub(2'h3, 0, 0);
    sub(2'h0, 4, 0);
    sub(2'h1, 4, 3);
    wr(1, 8'h30);
    i_perr_driven = 1'b1;
    @(negedge i_clk);
    chk({o_serr_out, o_serr_oe}, 2'h1);
    i_perr_driven = 1'b0;
    i_perr_n = 1'b0;
    repeat (6) @(negedge i_clk);
    chk(o_serr_oe, 1'b1);
    wr(1, 8'h10);
    repeat (2) @(negedge i_clk);
    chk(o_serr_oe, 1'b0);
    i_perr_n = 1'b1;
    usb(8'he4, 5'h02);
    usb(8'h24, 5'h01);
    buf_run(8'h10, 4'(PBFC_WBUF_BYTES / PBFC_WORD_BYTES));
    buf_run(8'h00, 4'h1);
    test_done();
  end

  // run needs well under 2000 cycles
  initial begin
    #40000;
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
